// File: sssir_regs.sv
`timescale 1ns/100ps
`default_nettype none
module sssir_regs
  import sssir_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic engineReq,
  input wire logic transactionDone,
  input wire logic receiveBufferFull,
  output logic engineGrant,
  output logic irq
);
  import sssir_pkg::*;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  logic awHeld;
  logic wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic next_awHeld;
  logic next_wHeld;
  logic [11:0] next_awAddr;
  logic [31:0] next_wData;
  logic [3:0] next_wStrb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic doWrite;

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == OFF_ACQUIRE_TASK) || (a == OFF_RELEASE_TASK) || (a == OFF_DONE_EVENT)
      || (a == OFF_RXFULL_EVENT) || (a == OFF_ACQUIRED_EVENT) || (a == OFF_SHORTCUTS)
      || (a == OFF_INT_SET) || (a == OFF_INT_CLEAR) || (a == OFF_SEM_STATUS);
  endfunction

  always_comb
  begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = {s_axi_awaddr[11:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    doWrite = awHeld && wHeld && !s_axi_bvalid;
    if (doWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 12'h000;
      wData <= ZERO_WORD;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_awready <= !next_awHeld;
      s_axi_wready <= !next_wHeld;
    end
  end
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wrLow;
  logic wrHigh;
  logic acquireTask;
  logic releaseTask;
  logic acquireReq;
  logic granted;
  logic [1:0] ownerCode;
  logic [10:0] intEnables;
  logic [10:0] setMask;
  logic [10:0] clearMask;
  logic doneFlag;
  logic rxFullFlag;
  logic acquiredFlag;
  logic shortcut;
  logic next_doneFlag;
  logic next_rxFullFlag;
  logic next_acquiredFlag;
  logic next_shortcut;
  logic [10:0] flagVector;
  logic doneEvent;

  always_comb
  begin
    wrLow = doWrite && wStrb[0];
    wrHigh = doWrite && wStrb[1];
    acquireTask = wrLow && (awAddr == OFF_ACQUIRE_TASK) && wData[0];
    releaseTask = wrLow && (awAddr == OFF_RELEASE_TASK) && wData[0];
    doneEvent = transactionDone && engineGrant;
    acquireReq = acquireTask || (shortcut && doneEvent);
    setMask = 11'h000;
    clearMask = 11'h000;
    // Only ones act; zeros written here leave enables alone.
    if (awAddr == OFF_INT_SET)
    begin
      setMask[BIT_DONE] = wrLow && wData[BIT_DONE];
      setMask[BIT_RXFULL] = wrLow && wData[BIT_RXFULL];
      setMask[BIT_ACQUIRED] = wrHigh && wData[BIT_ACQUIRED];
    end
    if (awAddr == OFF_INT_CLEAR)
    begin
      clearMask[BIT_DONE] = wrLow && wData[BIT_DONE];
      clearMask[BIT_RXFULL] = wrLow && wData[BIT_RXFULL];
      clearMask[BIT_ACQUIRED] = wrHigh && wData[BIT_ACQUIRED];
    end
    flagVector = 11'h000;
    flagVector[BIT_DONE] = doneFlag;
    flagVector[BIT_RXFULL] = rxFullFlag;
    flagVector[BIT_ACQUIRED] = acquiredFlag;
  end

  // ----------------------------------------------------------------
  // Event flags and shortcut
  // ----------------------------------------------------------------
  // A hardware set in the same cycle as a software write wins.
  always_comb
  begin
    next_doneFlag = doneFlag;
    next_rxFullFlag = rxFullFlag;
    next_acquiredFlag = acquiredFlag;
    next_shortcut = shortcut;
    if (wrLow && (awAddr == OFF_DONE_EVENT))
    begin
      next_doneFlag = wData[0];
    end
    if (wrLow && (awAddr == OFF_RXFULL_EVENT))
    begin
      next_rxFullFlag = wData[0];
    end
    if (wrLow && (awAddr == OFF_ACQUIRED_EVENT))
    begin
      next_acquiredFlag = wData[0];
    end
    if (wrLow && (awAddr == OFF_SHORTCUTS))
    begin
      next_shortcut = wData[BIT_SHORT_DONE_ACQ];
    end
    if (doneEvent)
    begin
      next_doneFlag = 1'b1;
    end
    if (receiveBufferFull)
    begin
      next_rxFullFlag = 1'b1;
    end
    if (granted)
    begin
      next_acquiredFlag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      doneFlag <= 1'b0;
      rxFullFlag <= 1'b0;
      acquiredFlag <= 1'b0;
      shortcut <= 1'b0;
    end
    else
    begin
      doneFlag <= next_doneFlag;
      rxFullFlag <= next_rxFullFlag;
      acquiredFlag <= next_acquiredFlag;
      shortcut <= next_shortcut;
    end
  end

  // ----------------------------------------------------------------
  // Semaphore and interrupt
  // ----------------------------------------------------------------
  logic engineGrantRaw;

  sssir_semaphore u_sem (
    .clk(clk),
    .sys_rst(sys_rst),
    .acquireReq(acquireReq),
    .releaseReq(releaseTask),
    .engineReq(engineReq),
    .engineDone(transactionDone),
    .ownerCode(ownerCode),
    .granted(granted),
    .engineGrant(engineGrantRaw)
  );

  sssir_irq u_irq (
    .clk(clk),
    .sys_rst(sys_rst),
    .setMask(setMask),
    .clearMask(clearMask),
    .flags(flagVector),
    .enables(intEnables),
    .irq(irq)
  );

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      engineGrant <= 1'b0;
    end
    else
    begin
      engineGrant <= engineGrantRaw;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] readWord;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;

  always_comb
  begin
    readWord = ZERO_WORD;
    unique case ({s_axi_araddr[11:2], 2'h0})
      OFF_DONE_EVENT: readWord[0] = doneFlag;
      OFF_RXFULL_EVENT: readWord[0] = rxFullFlag;
      OFF_ACQUIRED_EVENT: readWord[0] = acquiredFlag;
      OFF_SHORTCUTS: readWord[BIT_SHORT_DONE_ACQ] = shortcut;
      OFF_INT_SET: readWord[10:0] = intEnables;
      OFF_INT_CLEAR: readWord[10:0] = intEnables;
      OFF_SEM_STATUS: readWord[1:0] = ownerCode;
      default: readWord = ZERO_WORD;
    endcase
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata = readWord;
      next_rresp = isMapped({s_axi_araddr[11:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_rdata <= ZERO_WORD;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else
    begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= !next_rvalid;
    end
  end
endmodule // sssir_regs
`default_nettype wire

// File: sssir_pkg.sv
package sssir_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_ACQUIRE_TASK = 12'h024;
  localparam logic [11:0] OFF_RELEASE_TASK = 12'h028;
  localparam logic [11:0] OFF_DONE_EVENT = 12'h104;
  localparam logic [11:0] OFF_RXFULL_EVENT = 12'h110;
  localparam logic [11:0] OFF_ACQUIRED_EVENT = 12'h128;
  localparam logic [11:0] OFF_SHORTCUTS = 12'h200;
  localparam logic [11:0] OFF_INT_SET = 12'h304;
  localparam logic [11:0] OFF_INT_CLEAR = 12'h308;
  localparam logic [11:0] OFF_SEM_STATUS = 12'h400;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_DONE = 1;
  localparam int BIT_RXFULL = 4;
  localparam int BIT_ACQUIRED = 10;
  localparam int BIT_SHORT_DONE_ACQ = 0;
  localparam logic [10:0] INT_EN_RESET = 11'h000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Semaphore ownership codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEM_FREE = 2'h0;
  localparam logic [1:0] SEM_CPU = 2'h1;
  localparam logic [1:0] SEM_ENGINE = 2'h2;
  localparam logic [1:0] SEM_WAITING = 2'h3;

  typedef enum logic [1:0] {
    SSSIR_FREE,
    SSSIR_CPU,
    SSSIR_ENGINE,
    SSSIR_HANDOVER
  } sssir_sem_t;

  // Events raised by the register bank toward the interrupt block.
  typedef struct packed {
    logic acquired;
    logic rxFull;
    logic done;
  } sssir_events_t;

endpackage

// File: sssir_semaphore.sv
`timescale 1ns/100ps
`default_nettype none
module sssir_semaphore
  import sssir_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic acquireReq,
  input wire logic releaseReq,
  input wire logic engineReq,
  input wire logic engineDone,
  output logic [1:0] ownerCode,
  output logic granted,
  output logic engineGrant
);
  sssir_sem_t state;
  sssir_sem_t next_state;
  logic next_granted;

  always_comb
  begin
    next_state = state;
    next_granted = 1'b0;
    unique case (state)
      SSSIR_FREE:
      begin
        if (acquireReq)
        begin
          next_state = SSSIR_CPU;
          next_granted = 1'b1;
        end
        else if (engineReq)
        begin
          next_state = SSSIR_ENGINE;
        end
      end
      SSSIR_CPU:
      begin
        if (releaseReq)
        begin
          next_state = SSSIR_FREE;
        end
      end
      SSSIR_ENGINE:
      begin
        if (acquireReq)
        begin
          next_state = SSSIR_HANDOVER;
        end
        if (engineDone)
        begin
          next_state = acquireReq ? SSSIR_CPU : SSSIR_FREE;
          next_granted = acquireReq;
        end
      end
      SSSIR_HANDOVER:
      begin
        if (engineDone)
        begin
          next_state = SSSIR_CPU;
          next_granted = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= SSSIR_CPU;
      granted <= 1'b0;
    end
    else
    begin
      state <= next_state;
      granted <= next_granted;
    end
  end

  always_comb
  begin
    unique case (state)
      SSSIR_FREE: ownerCode = SEM_FREE;
      SSSIR_CPU: ownerCode = SEM_CPU;
      SSSIR_ENGINE: ownerCode = SEM_ENGINE;
      SSSIR_HANDOVER: ownerCode = SEM_WAITING;
    endcase
    engineGrant = (state == SSSIR_ENGINE) || (state == SSSIR_HANDOVER);
  end
endmodule // sssir_semaphore
`default_nettype wire

// File: sssir_irq.sv
`timescale 1ns/100ps
`default_nettype none
module sssir_irq
  import sssir_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [10:0] setMask,
  input wire logic [10:0] clearMask,
  input wire logic [10:0] flags,
  output logic [10:0] enables,
  output logic irq
);
  logic [10:0] next_enables;
  logic next_irq;

  always_comb
  begin
    next_enables = (enables | setMask) & ~clearMask;
    next_irq = |(flags & enables);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      enables <= INT_EN_RESET;
      irq <= 1'b0;
    end
    else
    begin
      enables <= next_enables;
      irq <= next_irq;
    end
  end
endmodule // sssir_irq
`default_nettype wire

// File: sssir_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sssir_regs_chk
  import sssir_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic engineReq,
  input wire logic transactionDone,
  input wire logic engineGrant
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  property p_rdAnswer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rdAnswer: assert property (p_rdAnswer) else $error("read answer missing");
  property p_rdHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read answer dropped");
  property p_wrAnswer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wrAnswer: assert property (p_wrAnswer) else $error("write answer missing");
  property p_wrHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wrHold: assert property (p_wrHold) else $error("write answer dropped");
  // ----------------------------------------------------------------
  // Register words and semaphore
  // ----------------------------------------------------------------
  property p_statusWord;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_SEM_STATUS |=> s_axi_rdata[31:2] == 30'h0;
  endproperty
  a_statusWord: assert property (p_statusWord) else $error("owner word has stray bits");
  property p_flagWord;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_ACQUIRED_EVENT |=> s_axi_rdata[31:1] == 31'h0;
  endproperty
  a_flagWord: assert property (p_flagWord) else $error("flag word has stray bits");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0FC |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == ZERO_WORD;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  // A grant can only follow a request seen while the semaphore was free.
  property p_engineRise;
    $rose(engineGrant) |-> $past(engineReq, 2);
  endproperty
  a_engineRise: assert property (p_engineRise) else $error("grant without request");
  property p_engineEnd;
    transactionDone && engineGrant |-> ##2 !engineGrant;
  endproperty
  a_engineEnd: assert property (p_engineEnd) else $error("engine kept semaphore");
endmodule // sssir_regs_chk
bind sssir_regs sssir_regs_chk sssir_regs_chk_i (.clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .engineReq(engineReq), .transactionDone(transactionDone),
  .engineGrant(engineGrant));
`default_nettype wire

// File: sssir_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module sssir_engine_model
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic engineGrant,
  input wire logic [2:0] cmd,
  output logic engineReq,
  output logic transactionDone,
  output logic receiveBufferFull
);
  // The request is held until granted, since a request seen while busy is ignored.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      engineReq <= 1'b0;
      transactionDone <= 1'b0;
      receiveBufferFull <= 1'b0;
    end
    else
    begin
      engineReq <= cmd[0] | (engineReq & ~engineGrant);
      transactionDone <= cmd[1];
      receiveBufferFull <= cmd[2];
    end
  end
endmodule // sssir_engine_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sssir_pkg::*;
  localparam logic [31:0] M = (32'h1 << BIT_DONE) | (32'h1 << BIT_RXFULL) | (32'h1 << BIT_ACQUIRED);
  logic clk = 1'b0, sys_rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, en;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic engineReq, transactionDone, receiveBufferFull, engineGrant, irq;
  logic [2:0] cmd = 3'h0;
  logic [33:0] expQ [$];
  logic [1:0] respQ [$];
  int num_errors = 0, checks = 0;
  always #2 clk = ~clk;
  sssir_regs sssir_regs_i (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .engineReq(engineReq), .transactionDone(transactionDone), .receiveBufferFull(receiveBufferFull),
    .engineGrant(engineGrant), .irq(irq));
  sssir_engine_model sssir_engine_model_i (.clk(clk), .sys_rst(sys_rst), .engineGrant(engineGrant), .cmd(cmd),
    .engineReq(engineReq), .transactionDone(transactionDone), .receiveBufferFull(receiveBufferFull));
  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 100)
    begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs = RESP_OKAY);
    int n;
    n = 0;
    respQ.push_back(rs);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    bound(n);
  endtask
  // Expected words are noted here and compared by the monitor when the answer comes.
  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [1:0] rs = RESP_OKAY);
    int n;
    n = 0;
    expQ.push_back({rs, v});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    bound(n);
  endtask
  task automatic eng(input logic [2:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 3'h0;
  endtask
  task automatic wg(input logic v);
    int n;
    for (n = 0; n < 100 && engineGrant !== v; n++) @(posedge clk);
    bound(n);
  endtask
  always @(posedge clk)
  begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmpResp(s_axi_bresp, respQ.pop_front());
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h9eed));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFF_ACQUIRED_EVENT, ZERO_WORD);
    rd(OFF_SHORTCUTS, ZERO_WORD);
    rd(OFF_INT_SET, ZERO_WORD);
    rd(OFF_SEM_STATUS, 32'h1);
    rd(12'h0FC, ZERO_WORD, RESP_SLVERR);
    wr(12'h0FC, 32'hFFFFFFFF, RESP_SLVERR);
    rd(OFF_INT_SET, ZERO_WORD);
    en = ZERO_WORD;
    repeat (6)
    begin
      r = $urandom;
      wr(OFF_INT_SET, r);
      en = en | (r & M);
      rd(OFF_INT_SET, en);
      r = $urandom;
      wr(OFF_INT_CLEAR, r);
      en = en & ~(r & M);
      rd(OFF_INT_CLEAR, en);
    end
    wr(OFF_INT_CLEAR, 32'hFFFFFFFF);
    wr(OFF_INT_SET, 32'h1 << BIT_ACQUIRED);
    wr(OFF_RELEASE_TASK, 32'h1);
    rd(OFF_SEM_STATUS, SEM_FREE);
    eng(3'h1);
    wg(1'b1);
    rd(OFF_SEM_STATUS, SEM_ENGINE);
    wr(OFF_ACQUIRE_TASK, 32'h1);
    rd(OFF_SEM_STATUS, SEM_WAITING);
    cmp(irq, 1'b0);
    eng(3'h2);
    wg(1'b0);
    rd(OFF_SEM_STATUS, SEM_CPU);
    rd(OFF_ACQUIRED_EVENT, 32'h1);
    rd(OFF_DONE_EVENT, 32'h1);
    cmp(irq, 1'b1);
    wr(OFF_ACQUIRED_EVENT, ZERO_WORD);
    repeat (2) @(posedge clk);
    cmp(irq, 1'b0);
    wr(OFF_RELEASE_TASK, 32'h1);
    eng(3'h1);
    wg(1'b1);
    eng(3'h2);
    wg(1'b0);
    rd(OFF_SEM_STATUS, SEM_FREE);
    wr(OFF_SHORTCUTS, 32'h1);
    rd(OFF_SHORTCUTS, 32'h1);
    eng(3'h1);
    wg(1'b1);
    eng(3'h2);
    wg(1'b0);
    rd(OFF_SEM_STATUS, SEM_CPU);
    rd(OFF_ACQUIRED_EVENT, 32'h1);
    wr(OFF_ACQUIRED_EVENT, ZERO_WORD);
    wr(OFF_INT_SET, 32'h1 << BIT_RXFULL);
    eng(3'h4);
    rd(OFF_RXFULL_EVENT, 32'h1);
    cmp(irq, 1'b1);
    wr(OFF_INT_CLEAR, 32'h1 << BIT_RXFULL);
    repeat (2) @(posedge clk);
    cmp(irq, 1'b0);
    wr(OFF_RELEASE_TASK, 32'h1);
    wr(OFF_ACQUIRE_TASK, 32'h1);
    rd(OFF_SEM_STATUS, SEM_CPU);
    rd(OFF_ACQUIRED_EVENT, 32'h1);
    repeat (4) @(posedge clk);
    if (expQ.size() != 0 || respQ.size() != 0) num_errors++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
